// ===== spi_link_pkg.sv
// shared constants for the spi peripheral and its remote partner
// assumes one clock domain per end; pins are resolved inside spi_link_if
package spi_link_pkg;
  // ****************************************
  // pins
  // ****************************************
  localparam int         PIN_W     = 4;
  localparam int         PIN_SCK   = 0;
  localparam int         PIN_MOSI  = 1;
  localparam int         PIN_MISO  = 2;
  localparam int         PIN_SS    = 3;
  localparam logic [3:0] LINE_IDLE = 4'h8;
  // ****************************************
  // register map
  // ****************************************
  localparam int         ADDR_W      = 3;
  localparam int         DATA_W      = 8;
  localparam logic [2:0] OFS_CTRL_A  = 3'h0;
  localparam logic [2:0] OFS_CTRL_B  = 3'h1;
  localparam logic [2:0] OFS_IRQ_EN  = 3'h2;
  localparam logic [2:0] OFS_FLAGS   = 3'h3;
  localparam logic [2:0] OFS_DATA    = 3'h4;
  localparam int         CA_ENABLE   = 0;
  localparam int         CA_HOST     = 1;
  localparam int         CA_SS_OUT   = 2;
  localparam int         CA_SS_LEVEL = 3;
  localparam int         CA_MISO_OUT = 4;
  localparam int         CB_SSD      = 2;
  localparam int         CB_BUFFER_WAIT_RECEIVE    = 6;
  localparam int         CB_BUFFER_MODE_ENABLE    = 7;
  localparam int         IE_DONE     = 0;
  localparam int         IE_DRE      = 5;
  localparam int         IE_TXC      = 6;
  localparam int         IE_RXC      = 7;
  localparam int         FL_DONE     = 7;
  localparam int         FL_WRITE_COLLISION_FLAG    = 6;
  localparam int         FL_RXC      = 7;
  localparam int         FL_TXC      = 6;
  localparam int         FL_DRE      = 5;
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic       DRE_RESET   = 1'h1;
  // ****************************************
  // framing
  // ****************************************
  localparam logic [2:0] LAST_BIT    = 3'h7;
  localparam logic [1:0] RX_DEPTH    = 2'h2;

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic b);
    return {s[6:0], b};
  endfunction : shift_in
endpackage : spi_link_pkg

// ===== spi_link_if.sv
// spi link between the peripheral and its remote partner
// assumes each party drives only its own output and enable vectors
`timescale 1ns/1ps
interface spi_link_if;
  logic [spi_link_pkg::PIN_W-1:0] dev_o;
  logic [spi_link_pkg::PIN_W-1:0] dev_oe;
  logic [spi_link_pkg::PIN_W-1:0] far_o;
  logic [spi_link_pkg::PIN_W-1:0] far_oe;
  logic [spi_link_pkg::PIN_W-1:0] line;

  // undriven wires fall to their idle level
  for (genvar i = 0; i < spi_link_pkg::PIN_W; i++) begin : g_pin
    assign line[i] = dev_oe[i] ? dev_o[i] : (far_oe[i] ? far_o[i] : spi_link_pkg::LINE_IDLE[i]);
  end

  modport device (input line, output dev_o, output dev_oe);
  modport far    (input line, output far_o, output far_oe);
endinterface : spi_link_if

// ===== spi_sync2.sv
// two flip-flop synchroniser for a vector of pin levels
// assumes each bit is a level from another domain
`timescale 1ns/1ps
module spi_sync2 #(
  parameter int           W         = 4,
  parameter logic [W-1:0] RESET_VAL = '0  // idle pin levels, so no false edge follows reset
) (
  input  wire logic         clk_in,     // local clock
  input  wire logic         reset_n_in, // async reset
  input  wire logic [W-1:0] d_in,       // raw levels
  output logic      [W-1:0] q_out       // synchronised levels
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta  <= RESET_VAL;
      q_out <= RESET_VAL;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : spi_sync2

// ===== spi_peripheral.sv
// spi peripheral with host and client roles, normal and buffer modes
// assumes pins through spi_link_if; registers on a plain strobe port
//
// Overview of operation
// - host write to data starts transfer
// - host normal early write corrupts, flags collision
// - normal mode received byte lands after transfer
// - normal done flag with its interrupt enable
// - buffer enable bit; wait bit ignored as host
// - host buffer: first write sends, next buffered
// - buffer mode two entry receive fifo
// - all sent flag with its interrupt enable
// - select disable bit: host ignores the select pin
// - select as output never affects host
// - low select input demotes host, sets done
// - software rechecks and restores host bit
// - remote sck phases exceed two clocks
// - client idle until selected, then shifts
// - client done flag after full byte
// - client early write dropped, flags collision
// - deselect halts client, drops partial byte
// - client wait zero: buffered, dummy first
// - write into full buffer is dropped
// - buffer empty flag falls on a write into the buffer (not a host direct send), rises on move
// - receive then all sent flags, one apart
// - client wait one: data ready at select
`timescale 1ns/1ps
module spi_peripheral #(
  parameter int SCK_HALF_CYCLES = 8
) (
  input  wire logic                              clk_in,        // 10 MHz clock
  input  wire logic                              reset_n_in,    // async reset
  input  wire logic [spi_link_pkg::ADDR_W-1:0]   reg_addr_in,   // register address
  input  wire logic [spi_link_pkg::DATA_W-1:0]   reg_wdata_in,  // write data
  input  wire logic                              reg_write_in,  // write strobe
  input  wire logic                              reg_read_in,   // read strobe
  output logic      [spi_link_pkg::DATA_W-1:0]   reg_rdata_out, // read data, next cycle
  output logic                                   irq_out,       // interrupt request
  spi_link_if.device                             link           // spi pins
);
  localparam int DIV_W = $clog2(SCK_HALF_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYCLES - 1);
  if (SCK_HALF_CYCLES < 3) begin : g_chk
    $error("SCK_HALF_CYCLES must be at least 3");
  end

  // ****************************************
  // state
  // ****************************************
  logic [3:0]       line_s;
  logic             sck_q;
  logic             enable, host, ss_out, ss_level, miso_out;
  logic             buffer_mode_enable, buffer_wait_receive, select_pin_disable;
  logic             ie_done, ie_dre, ie_txc, ie_rxc;
  logic             f_done, f_write_collision_flag, f_rxc, f_txc, f_dre;
  logic [7:0]       shreg, txb, rx_hold;
  logic             in_bit, busy, loaded, txb_full, sck_r;
  logic [2:0]       cnt;
  logic [DIV_W-1:0] div;
  logic             done_d1, done_d2;
  logic [7:0]       rx_mem [2];
  logic             rx_wp, rx_rp;
  logic [1:0]       rx_cnt;

  spi_sync2 #(.W(spi_link_pkg::PIN_W), .RESET_VAL(spi_link_pkg::LINE_IDLE)) u_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .d_in       (link.line),
    .q_out      (line_s)
  );

  // ****************************************
  // decode
  // ****************************************
  logic wr_data, rd_data, wr_flags, is_host, demote, selected, abort, tick;
  logic rise, fall, byte_done, collision, buf_direct, buf_to_txb, load_wr, move, push, pop;
  logic [7:0] rx_byte;
  always_comb begin
    wr_data    = reg_write_in && reg_addr_in == spi_link_pkg::OFS_DATA;
    rd_data    = reg_read_in && reg_addr_in == spi_link_pkg::OFS_DATA;
    wr_flags   = reg_write_in && reg_addr_in == spi_link_pkg::OFS_FLAGS;
    is_host    = enable && host;
    demote     = is_host && !select_pin_disable && !ss_out && !line_s[spi_link_pkg::PIN_SS];
    selected   = enable && !host && !line_s[spi_link_pkg::PIN_SS];
    abort      = demote || (!is_host && !selected);
    tick       = is_host && busy && div == DIV_LAST;
    rise       = is_host ? (tick && !sck_r) : (selected && line_s[spi_link_pkg::PIN_SCK] && !sck_q);
    fall       = is_host ? (tick && sck_r) : (selected && !line_s[spi_link_pkg::PIN_SCK] && sck_q);
    byte_done  = fall && cnt == spi_link_pkg::LAST_BIT;
    rx_byte    = spi_link_pkg::shift_in(shreg, in_bit);
    collision  = wr_data && !buffer_mode_enable && busy;
    buf_direct = wr_data && buffer_mode_enable && is_host && !busy && !txb_full;
    buf_to_txb = wr_data && buffer_mode_enable && !buf_direct && !txb_full;
    load_wr    = (wr_data && !buffer_mode_enable && (is_host || !busy)) || buf_direct;
    // wait-for-receive only matters as client; host ignores it
    move       = buffer_mode_enable && txb_full && (byte_done ||
                 (!is_host && buffer_wait_receive && !selected && !loaded));
    push       = byte_done && buffer_mode_enable && rx_cnt < spi_link_pkg::RX_DEPTH;
    pop        = rd_data && buffer_mode_enable && rx_cnt != 2'h0;
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {enable, host, ss_out, ss_level, miso_out} <= '0;
      {buffer_mode_enable, buffer_wait_receive, select_pin_disable}                        <= '0;
      {ie_done, ie_dre, ie_txc, ie_rxc}          <= '0;
    end else begin
      if (reg_write_in && reg_addr_in == spi_link_pkg::OFS_CTRL_A) begin
        enable   <= reg_wdata_in[spi_link_pkg::CA_ENABLE];
        host     <= reg_wdata_in[spi_link_pkg::CA_HOST];
        ss_out   <= reg_wdata_in[spi_link_pkg::CA_SS_OUT];
        ss_level <= reg_wdata_in[spi_link_pkg::CA_SS_LEVEL];
        miso_out <= reg_wdata_in[spi_link_pkg::CA_MISO_OUT];
      end
      if (demote) begin
        host <= 1'b0;
      end
      if (reg_write_in && reg_addr_in == spi_link_pkg::OFS_CTRL_B) begin
        buffer_mode_enable <= reg_wdata_in[spi_link_pkg::CB_BUFFER_MODE_ENABLE];
        buffer_wait_receive <= reg_wdata_in[spi_link_pkg::CB_BUFFER_WAIT_RECEIVE];
        select_pin_disable   <= reg_wdata_in[spi_link_pkg::CB_SSD];
      end
      if (reg_write_in && reg_addr_in == spi_link_pkg::OFS_IRQ_EN) begin
        ie_done <= reg_wdata_in[spi_link_pkg::IE_DONE];
        ie_dre  <= reg_wdata_in[spi_link_pkg::IE_DRE];
        ie_txc  <= reg_wdata_in[spi_link_pkg::IE_TXC];
        ie_rxc  <= reg_wdata_in[spi_link_pkg::IE_RXC];
      end
    end
  end

  // ****************************************
  // shift engine
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shreg <= spi_link_pkg::BYTE_RESET;
    end else if (load_wr) begin
      shreg <= reg_wdata_in;
    end else if (move) begin
      shreg <= txb;
    end else if (fall) begin
      shreg <= rx_byte;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      in_bit <= 1'b0;
      sck_q  <= 1'b0;
    end else begin
      sck_q <= line_s[spi_link_pkg::PIN_SCK];
      if (rise) begin
        in_bit <= is_host ? line_s[spi_link_pkg::PIN_MISO] : line_s[spi_link_pkg::PIN_MOSI];
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt  <= 3'h0;
      busy <= 1'b0;
    end else if (abort) begin
      cnt  <= 3'h0;
      busy <= 1'b0;
    end else begin
      if (fall) begin
        cnt <= cnt + 3'h1;
      end
      if (is_host) begin
        if (load_wr || move) begin
          busy <= 1'b1;
        end else if (byte_done) begin
          busy <= 1'b0;
        end
      end else if (rise) begin
        busy <= 1'b1;
      end else if (byte_done) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div   <= '0;
      sck_r <= 1'b0;
    end else if (!(is_host && busy)) begin
      div   <= '0;
      sck_r <= 1'b0;
    end else if (tick) begin
      div   <= '0;
      sck_r <= !sck_r;
    end else begin
      div <= div + DIV_W'(1);
    end
  end

  // ****************************************
  // transmit buffer and receive side
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      txb      <= spi_link_pkg::BYTE_RESET;
      txb_full <= 1'b0;
      loaded   <= 1'b0;
    end else begin
      if (buf_to_txb) begin
        txb      <= reg_wdata_in;
        txb_full <= 1'b1;
      end else if (move) begin
        txb_full <= 1'b0;
      end
      if (load_wr || move) begin
        loaded <= 1'b1;
      end else if (byte_done) begin
        loaded <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_hold <= spi_link_pkg::BYTE_RESET;
      rx_mem  <= '{default: spi_link_pkg::BYTE_RESET};
      rx_wp   <= 1'b0;
      rx_rp   <= 1'b0;
      rx_cnt  <= 2'h0;
    end else begin
      if (byte_done && !buffer_mode_enable) begin
        rx_hold <= rx_byte;
      end
      if (push) begin
        rx_mem[rx_wp] <= rx_byte;
        rx_wp         <= !rx_wp;
      end
      if (pop) begin
        rx_rp <= !rx_rp;
      end
      rx_cnt <= rx_cnt + 2'(push) - 2'(pop);
    end
  end

  // ****************************************
  // flags; hardware set wins over clear
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {f_done, f_write_collision_flag, f_rxc, f_txc} <= '0;
      f_dre                           <= spi_link_pkg::DRE_RESET;
      done_d1                         <= 1'b0;
      done_d2                         <= 1'b0;
    end else begin
      done_d1 <= byte_done && buffer_mode_enable;
      done_d2 <= done_d1;
      if ((byte_done && !buffer_mode_enable) || demote) begin
        f_done <= 1'b1;
      end else if (wr_flags && reg_wdata_in[spi_link_pkg::FL_DONE] && !buffer_mode_enable) begin
        f_done <= 1'b0;
      end
      if (collision) begin
        f_write_collision_flag <= 1'b1;
      end else if (wr_flags && reg_wdata_in[spi_link_pkg::FL_WRITE_COLLISION_FLAG] && !buffer_mode_enable) begin
        f_write_collision_flag <= 1'b0;
      end
      if (done_d1) begin
        f_rxc <= 1'b1;
      end else if (wr_flags && reg_wdata_in[spi_link_pkg::FL_RXC] && buffer_mode_enable) begin
        f_rxc <= 1'b0;
      end
      if (done_d2 && !loaded && !txb_full) begin
        f_txc <= 1'b1;
      end else if (wr_flags && reg_wdata_in[spi_link_pkg::FL_TXC] && buffer_mode_enable) begin
        f_txc <= 1'b0;
      end
      if (move) begin
        f_dre <= 1'b1;
      end else if (buf_to_txb) begin
        f_dre <= 1'b0;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_out       <= 1'b0;
      reg_rdata_out <= spi_link_pkg::BYTE_RESET;
      link.dev_o    <= '0;
      link.dev_oe   <= '0;
    end else begin
      irq_out <= buffer_mode_enable ? ((f_rxc && ie_rxc) || (f_txc && ie_txc) || (f_dre && ie_dre))
                       : ((f_done || f_write_collision_flag) && ie_done);
      reg_rdata_out <= spi_link_pkg::BYTE_RESET;
      if (reg_read_in) begin
        case (reg_addr_in)
          spi_link_pkg::OFS_CTRL_A: reg_rdata_out <= {3'h0, miso_out, ss_level, ss_out, host, enable};
          spi_link_pkg::OFS_CTRL_B: reg_rdata_out <= {buffer_mode_enable, buffer_wait_receive, 3'h0, select_pin_disable, 2'h0};
          spi_link_pkg::OFS_IRQ_EN: reg_rdata_out <= {ie_rxc, ie_txc, ie_dre, 4'h0, ie_done};
          spi_link_pkg::OFS_FLAGS:  reg_rdata_out <= buffer_mode_enable ? {f_rxc, f_txc, f_dre, 5'h00}
                                                           : {f_done, f_write_collision_flag, 6'h00};
          spi_link_pkg::OFS_DATA:   reg_rdata_out <= buffer_mode_enable ? rx_mem[rx_rp] : rx_hold;
          default:                  reg_rdata_out <= spi_link_pkg::BYTE_RESET;
        endcase
      end
      link.dev_o[spi_link_pkg::PIN_SCK]   <= sck_r;
      link.dev_oe[spi_link_pkg::PIN_SCK]  <= is_host;
      link.dev_o[spi_link_pkg::PIN_MOSI]  <= shreg[7];
      link.dev_oe[spi_link_pkg::PIN_MOSI] <= is_host;
      link.dev_o[spi_link_pkg::PIN_MISO]  <= shreg[7];
      link.dev_oe[spi_link_pkg::PIN_MISO] <= selected && miso_out;
      link.dev_o[spi_link_pkg::PIN_SS]    <= ss_level;
      link.dev_oe[spi_link_pkg::PIN_SS]   <= is_host && ss_out;
    end
  end
endmodule : spi_peripheral

// ===== spi_remote.sv
// remote spi party: host that makes sck by a divider, or a select-driven client
// assumes mode 0, msb first, one byte per select frame
`timescale 1ns/1ps
module spi_remote #(
  parameter int SCK_HALF_CYCLES = 8
) (
  input  wire logic       clk_in,      // local clock
  input  wire logic       reset_n_in,  // async reset
  input  wire logic       role_host_in,// 1 host, 0 client
  input  wire logic       start_in,    // load byte, start as host
  input  wire logic [7:0] tx_data_in,  // byte to send
  output logic      [7:0] rx_data_out, // byte received
  output logic            done_out,    // byte complete pulse
  output logic            busy_out,    // frame in progress
  spi_link_if.far         link         // spi pins
);
  localparam int DIV_W = $clog2(SCK_HALF_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYCLES - 1);
  if (SCK_HALF_CYCLES < 3) begin : g_chk
    $error("SCK_HALF_CYCLES must exceed two clocks");
  end

  typedef enum logic [1:0] {F_IDLE, F_LEAD, F_SHIFT, F_TRAIL} far_state_e;
  far_state_e       state;
  logic [3:0]       line_s;
  logic             sck_q, sck_r, ss_r, in_bit;
  logic [7:0]       shreg;
  logic [2:0]       cnt;
  logic [DIV_W-1:0] div;
  logic             tick, sel, rise, fall, last;

  spi_sync2 #(.W(spi_link_pkg::PIN_W), .RESET_VAL(spi_link_pkg::LINE_IDLE)) u_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .d_in       (link.line),
    .q_out      (line_s)
  );

  always_comb begin
    tick = div == DIV_LAST;
    sel  = !role_host_in && !line_s[spi_link_pkg::PIN_SS];
    rise = role_host_in ? (state == F_SHIFT && tick && !sck_r)
                        : (sel && line_s[spi_link_pkg::PIN_SCK] && !sck_q);
    fall = role_host_in ? (state == F_SHIFT && tick && sck_r)
                        : (sel && !line_s[spi_link_pkg::PIN_SCK] && sck_q);
    last = fall && cnt == spi_link_pkg::LAST_BIT;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= F_IDLE;
      div   <= '0;
      sck_r <= 1'b0;
      ss_r  <= 1'b1;
    end else begin
      div <= (state == F_IDLE || tick) ? '0 : div + DIV_W'(1);
      case (state)
        F_IDLE:  if (start_in && role_host_in) begin
                   state <= F_LEAD;
                   ss_r  <= 1'b0;
                 end
        F_LEAD:  if (tick) begin
                   state <= F_SHIFT;
                 end
        F_SHIFT: if (tick) begin
                   sck_r <= !sck_r;
                   if (last) begin
                     state <= F_TRAIL;
                   end
                 end
        F_TRAIL: if (tick) begin
                   state <= F_IDLE;
                   ss_r  <= 1'b1;
                 end
        default: state <= F_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shreg       <= spi_link_pkg::BYTE_RESET;
      in_bit      <= 1'b0;
      sck_q       <= 1'b0;
      cnt         <= 3'h0;
      rx_data_out <= spi_link_pkg::BYTE_RESET;
      done_out    <= 1'b0;
      busy_out    <= 1'b0;
      link.far_o  <= '0;
      link.far_oe <= '0;
    end else begin
      sck_q    <= line_s[spi_link_pkg::PIN_SCK];
      done_out <= last;
      busy_out <= role_host_in ? state != F_IDLE : sel;
      if (rise) begin
        in_bit <= role_host_in ? line_s[spi_link_pkg::PIN_MISO] : line_s[spi_link_pkg::PIN_MOSI];
      end
      if (start_in && state == F_IDLE && cnt == 3'h0) begin
        shreg <= tx_data_in;
      end else if (fall) begin
        shreg <= spi_link_pkg::shift_in(shreg, in_bit);
      end
      if (!role_host_in && !sel) begin
        cnt <= 3'h0;
      end else if (fall) begin
        cnt <= cnt + 3'h1;
      end
      if (last) begin
        rx_data_out <= spi_link_pkg::shift_in(shreg, in_bit);
      end
      link.far_o[spi_link_pkg::PIN_SCK]   <= sck_r;
      // clock and data wait out the lead, so a host being demoted has let go first
      link.far_oe[spi_link_pkg::PIN_SCK]  <= role_host_in && (state == F_SHIFT || state == F_TRAIL);
      link.far_o[spi_link_pkg::PIN_MOSI]  <= shreg[7];
      link.far_oe[spi_link_pkg::PIN_MOSI] <= role_host_in && (state == F_SHIFT || state == F_TRAIL);
      link.far_o[spi_link_pkg::PIN_MISO]  <= shreg[7];
      link.far_oe[spi_link_pkg::PIN_MISO] <= sel;
      link.far_o[spi_link_pkg::PIN_SS]    <= ss_r;
      link.far_oe[spi_link_pkg::PIN_SS]   <= role_host_in;
    end
  end
endmodule : spi_remote

// ===== spi_link_properties.sv
// wire checks for the spi link between the two ends
// assumes the pin vectors of spi_link_if and one shared clock
`timescale 1ns/1ps
module spi_link_properties (
  input  wire logic       clk_in,     // clock
  input  wire logic       reset_n_in, // async reset
  input  wire logic [3:0] dev_o,      // device outputs
  input  wire logic [3:0] dev_oe,     // device enables
  input  wire logic [3:0] far_o,      // remote outputs
  input  wire logic [3:0] far_oe,     // remote enables
  input  wire logic [3:0] line        // resolved wires
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // ****
  // wire relations
  // ****
  a_sck_one_driver: assert property (!(dev_oe[0] && far_oe[0])) else $error("sck fight");
  a_sck_phase_min: assert property ($changed(line[0]) |=> $stable(line[0])[*2]) else $error("sck short");
  a_sck_high_len: assert property ($rose(line[0]) |-> ##[3:12] !line[0]) else $error("sck high long");
  a_idle_sck_still: assert property (far_oe[0] && line[3] && $past(line[3]) |-> $stable(line[0])) else $error("sck idle");
  a_sck_low_end: assert property ($rose(line[3]) |-> !line[0]) else $error("sck high at end");
  a_mosi_steady: assert property ($rose(line[0]) |-> $stable(line[1])) else $error("mosi moved");
  a_miso_steady: assert property ($rose(line[0]) && !line[3] |-> $stable(line[2])) else $error("miso moved");
  a_miso_released: assert property ($rose(line[3]) |-> ##[0:5] !dev_oe[2]) else $error("miso held");
endmodule : spi_link_properties

// ===== spi_host_client_buffered_tb_top.sv
// testbench: peripheral and remote joined by spi_link_if
// assumes mode 0, msb first, eight clock half periods at both ends
`timescale 1ns/1ps
module spi_host_client_buffered_tb_top;
  logic       clk_in, reset_n_in, w, r, role, st, irq, dn, bs;
  logic [2:0] a;
  logic [7:0] d, td, rdata, rx;
  int         errors, tests_run;
  logic [7:0] hb [2] = '{8'hA5, 8'h3C};
  logic [7:0] cb [2] = '{8'h5A, 8'hC3};
  spi_link_if lnk ();
  spi_peripheral spi_peripheral_inst (.clk_in, .reset_n_in, .reg_addr_in(a), .reg_wdata_in(d), .reg_write_in(w),
    .reg_read_in(r), .reg_rdata_out(rdata), .irq_out(irq), .link(lnk));
  spi_remote spi_remote_inst (.clk_in, .reset_n_in, .role_host_in(role), .start_in(st), .tx_data_in(td),
    .rx_data_out(rx), .done_out(dn), .busy_out(bs), .link(lnk));
  spi_link_properties spi_link_properties_inst (.clk_in, .reset_n_in, .dev_o(lnk.dev_o), .dev_oe(lnk.dev_oe),
    .far_o(lnk.far_o), .far_oe(lnk.far_oe), .line(lnk.line));
  // ****
  // tasks
  // ****
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [2:0] ad, input logic [7:0] v);
    @(posedge clk_in);
    a <= ad;
    d <= v;
    w <= 1'h1;
    @(posedge clk_in);
    w <= 1'h0;
  endtask : wr
  task automatic rd(input logic [2:0] ad, input logic [7:0] e);
    @(posedge clk_in);
    a <= ad;
    r <= 1'h1;
    @(posedge clk_in);
    r <= 1'h0;
    @(negedge clk_in);
    chk(rdata, e);
  endtask : rd
  task automatic go(input logic [7:0] v);
    @(posedge clk_in);
    td <= v;
    st <= 1'h1;
    @(posedge clk_in);
    st <= 1'h0;
  endtask : go
  task automatic wdone;
    for (int i = 0; i < 600 && dn !== 1'h1; i++) @(negedge clk_in);
    if (dn !== 1'h1) errors++;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
  endtask : wdone
  task automatic end_of_test;
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // ****
  // stimulus
  // ****
  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #3000000;
    errors++;
    end_of_test();
  end
  initial begin
    {reset_n_in, w, r, role, st, a, d, td} = '0;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'h1;
    repeat (3) @(posedge clk_in);
    rd(spi_link_pkg::OFS_FLAGS, 8'h00);
    rd(spi_link_pkg::OFS_CTRL_A, 8'h00);
    rd(3'h7, 8'h00);
    wr(spi_link_pkg::OFS_CTRL_B, 8'h80);
    rd(spi_link_pkg::OFS_FLAGS, 8'h20);
    wr(spi_link_pkg::OFS_CTRL_B, 8'h00);
    wr(spi_link_pkg::OFS_IRQ_EN, 8'h01);
    for (int i = 0; i < 2; i++) begin
      wr(spi_link_pkg::OFS_CTRL_A, 8'h0F);
      go(cb[i]);
      wr(spi_link_pkg::OFS_CTRL_A, 8'h07);
      wr(spi_link_pkg::OFS_DATA, hb[i]);
      wdone();
      chk(rx, hb[i]);
      chk({7'h00, irq}, 8'h01);
      rd(spi_link_pkg::OFS_FLAGS, 8'h80);
      rd(spi_link_pkg::OFS_DATA, cb[i]);
      wr(spi_link_pkg::OFS_FLAGS, 8'h80);
    end
    // remote becomes host and pulls select low
    wr(spi_link_pkg::OFS_CTRL_A, 8'h0F);
    role <= 1'h1;
    repeat (3) @(posedge clk_in);
    wr(spi_link_pkg::OFS_CTRL_A, 8'h03);
    rd(spi_link_pkg::OFS_CTRL_A, 8'h03);
    go(8'h96);
    wdone();
    rd(spi_link_pkg::OFS_CTRL_A, 8'h01);
    rd(spi_link_pkg::OFS_FLAGS, 8'h80);
    repeat (20) @(posedge clk_in);
    wr(spi_link_pkg::OFS_FLAGS, 8'hC0);
    wr(spi_link_pkg::OFS_CTRL_A, 8'h11);
    wr(spi_link_pkg::OFS_DATA, 8'hC3);
    go(8'h5A);
    repeat (60) @(posedge clk_in);
    wr(spi_link_pkg::OFS_DATA, 8'hFF);
    wdone();
    chk(rx, 8'hC3);
    rd(spi_link_pkg::OFS_FLAGS, 8'hC0);
    rd(spi_link_pkg::OFS_DATA, 8'h5A);
    // host buffer mode: one direct byte, one buffered, one dropped
    role <= 1'h0;
    wr(spi_link_pkg::OFS_CTRL_B, 8'h80);
    wr(spi_link_pkg::OFS_IRQ_EN, 8'h40);
    wr(spi_link_pkg::OFS_CTRL_A, 8'h0F);
    go(8'h3C);
    wr(spi_link_pkg::OFS_CTRL_A, 8'h07);
    wr(spi_link_pkg::OFS_DATA, 8'hA5);
    wr(spi_link_pkg::OFS_DATA, 8'h96);
    wr(spi_link_pkg::OFS_DATA, 8'hFF);
    rd(spi_link_pkg::OFS_FLAGS, 8'h00);
    wdone();
    chk(rx, 8'hA5);
    wdone();
    chk(rx, 8'h96);
    chk({7'h00, irq}, 8'h01);
    rd(spi_link_pkg::OFS_FLAGS, 8'hE0);
    rd(spi_link_pkg::OFS_DATA, 8'h3C);
    rd(spi_link_pkg::OFS_DATA, 8'hA5);
    end_of_test();
  end
endmodule : spi_host_client_buffered_tb_top
